// file: core/flc_top.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "flc_params.svh"
module flc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile image in and write back
  input wire logic nv_valid,
  input flc_pkg::flc_nv_t nv_image,
  output logic nv_wr,
  output flc_pkg::flc_nv_t nv_wr_image,
  // flash request port
  input wire logic dual_mode,
  input wire logic req_valid,
  input flc_pkg::flc_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_err,
  // flash engine
  output logic fl_cmd_valid,
  output flc_pkg::flc_req_t fl_cmd,
  input wire logic fl_busy,
  // memory access monitor
  input wire logic ax_valid,
  input wire logic ax_nonsecure,
  input wire logic ax_target_secure,
  output logic secure_fault,
  // port enables and interrupt
  output logic debug_en,
  output logic serial_en,
  output flc_pkg::flc_lc_t lc_state,
  output logic irq
);
  typedef enum logic [2:0] {st_idle, st_issue, st_gap, st_wait, st_finish} flc_init_t;
  flc_init_t st_q;
  flc_pkg::flc_prot_t temp_q, perm_q;
  logic [`FLC_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set, irq_clr;
  logic [`FLC_CNT_W-1:0] cnt_q;
  logic [`FLC_BLK_W-1:0] err_blk_q;
  logic [31:0] rd_d;
  logic ack_q, err_q, loaded_q, init_done, step_bad, locked, allow, take;
  logic wr_en, rd_hit, cnt_bank, cnt_skip, cnt_last, init_go, init_refuse;
  logic [`FLC_BLK_W-1:0] cnt_blk;
  flc_pkg::flc_nv_t img, img_prev_q;
  //////////////////////////////////////////////////////////////////////////
  // apb: one wait state, write lands on the completing edge
  assign pready = ack_q;
  assign pslverr = ack_q && err_q;
  assign wr_en = psel && penable && ack_q && pwrite && !err_q;
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `FLC_OFF_TEMP_LO0: rd_d = temp_q.low_blocks[`FLC_LO0_BITS-1:0];
      `FLC_OFF_TEMP_LO1: rd_d[4:0] = temp_q.low_blocks[`FLC_LOW_BLKS-1:`FLC_LO0_BITS];
      `FLC_OFF_TEMP_HI: rd_d = temp_q.high_blocks;
      `FLC_OFF_TEMP_DB: rd_d = temp_q.dual_bank;
      `FLC_OFF_PERM_LO0: rd_d = perm_q.low_blocks[`FLC_LO0_BITS-1:0];
      `FLC_OFF_PERM_LO1: rd_d[4:0] = perm_q.low_blocks[`FLC_LOW_BLKS-1:`FLC_LO0_BITS];
      `FLC_OFF_PERM_HI: rd_d = perm_q.high_blocks;
      `FLC_OFF_PERM_DB: rd_d = perm_q.dual_bank;
      `FLC_OFF_LC: rd_d[2:0] = lc_state;
      `FLC_OFF_CMD: rd_d = 32'h0000_0000;
      `FLC_OFF_STATUS: begin
        rd_d[`FLC_ST_BUSY] = st_q != st_idle;
        rd_d[`FLC_ST_DEBUG] = debug_en;
        rd_d[`FLC_ST_SERIAL] = serial_en;
        rd_d[`FLC_ST_DUAL] = dual_mode;
        rd_d[`FLC_ST_LOADED] = loaded_q;
      end
      `FLC_OFF_IRQ_STAT: rd_d[`FLC_IRQ_W-1:0] = irq_stat_q;
      `FLC_OFF_IRQ_MASK: rd_d[`FLC_IRQ_W-1:0] = irq_mask_q;
      `FLC_OFF_ERR_BLK: rd_d[`FLC_BLK_W-1:0] = err_blk_q;
      default: rd_hit = 1'b0;
    endcase
  end
  // access phase tracking and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ack_q <= psel && penable && !ack_q;
      if (psel && penable && !ack_q) begin
        err_q <= !rd_hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // protect words: writes only add locks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= '0;
      perm_q <= '0;
    end else if (nv_valid && !loaded_q) begin
      temp_q <= nv_image.temp_block_protect;
      perm_q <= nv_image.perm_block_protect;
    end else if (init_done) begin
      temp_q <= '0;
    end else if (wr_en && st_q == st_idle) begin
      unique case (paddr)
        `FLC_OFF_TEMP_LO0: temp_q.low_blocks[`FLC_LO0_BITS-1:0] <=
          temp_q.low_blocks[`FLC_LO0_BITS-1:0] | pwdata;
        `FLC_OFF_TEMP_LO1: temp_q.low_blocks[`FLC_LOW_BLKS-1:`FLC_LO0_BITS] <=
          temp_q.low_blocks[`FLC_LOW_BLKS-1:`FLC_LO0_BITS] | pwdata[4:0];
        `FLC_OFF_TEMP_HI: temp_q.high_blocks <= temp_q.high_blocks | pwdata;
        `FLC_OFF_TEMP_DB: temp_q.dual_bank <= temp_q.dual_bank | pwdata;
        `FLC_OFF_PERM_LO0: perm_q.low_blocks[`FLC_LO0_BITS-1:0] <=
          perm_q.low_blocks[`FLC_LO0_BITS-1:0] | pwdata;
        `FLC_OFF_PERM_LO1: perm_q.low_blocks[`FLC_LOW_BLKS-1:`FLC_LO0_BITS] <=
          perm_q.low_blocks[`FLC_LOW_BLKS-1:`FLC_LO0_BITS] | pwdata[4:0];
        `FLC_OFF_PERM_HI: perm_q.high_blocks <= perm_q.high_blocks | pwdata;
        `FLC_OFF_PERM_DB: perm_q.dual_bank <= perm_q.dual_bank | pwdata;
        default: ;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // nonvolatile load flag and write back on any change
  assign img = '{lc: lc_state, temp_block_protect: temp_q, perm_block_protect: perm_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      img_prev_q <= '0;
      nv_wr <= 1'b0;
      nv_wr_image <= '0;
    end else begin
      if (nv_valid) loaded_q <= 1'b1;
      img_prev_q <= img;
      nv_wr <= loaded_q && img != img_prev_q;
      nv_wr_image <= img;
    end
  end
  flc_lifecycle u_lc (
    .pclk(pclk),
    .presetn(presetn),
    .load_valid(nv_valid && !loaded_q),
    .load_state(nv_image.lc),
    .step_req(wr_en && paddr == `FLC_OFF_LC && st_q == st_idle),
    .step_target(pwdata[2:0]),
    .init_done(init_done),
    .lc_state(lc_state),
    .step_bad(step_bad),
    .debug_en(debug_en),
    .serial_en(serial_en)
  );
  //////////////////////////////////////////////////////////////////////////
  // initialise sequence: erase each block not held by a permanent lock
  assign init_go = wr_en && paddr == `FLC_OFF_CMD && pwdata[`FLC_CMD_INIT];
  assign init_refuse = init_go && (st_q != st_idle ||
                       lc_state >= flc_pkg::debug_locked_state);
  assign cnt_bank = cnt_q >= `FLC_CNT_W'(`FLC_NBLK);
  assign cnt_blk = cnt_bank ? `FLC_BLK_W'(cnt_q - `FLC_CNT_W'(`FLC_NBLK)) :
                   cnt_q[`FLC_BLK_W-1:0];
  assign cnt_skip = (cnt_bank && !dual_mode) ||
                    flc_pkg::prot_bit(perm_q, dual_mode, cnt_bank, cnt_blk);
  assign cnt_last = cnt_q == `FLC_CNT_W'(`FLC_NBLK + `FLC_DUAL_BLKS - 1);
  assign init_done = st_q == st_finish;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= st_idle;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        st_idle: if (init_go && !init_refuse) begin
          st_q <= st_issue;
          cnt_q <= '0;
        end
        st_issue: if (cnt_skip || !fl_busy) begin
          st_q <= cnt_skip ? (cnt_last ? st_finish : st_issue) : st_gap;
          if (cnt_skip) cnt_q <= cnt_q + 1'b1;
        end
        st_gap: st_q <= st_wait;
        st_wait: if (!fl_busy) begin
          st_q <= cnt_last ? st_finish : st_issue;
          cnt_q <= cnt_q + 1'b1;
        end
        st_finish: st_q <= st_idle;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // request port: judged in one cycle, answered the next
  flc_prot_check u_chk (
    .req(req),
    .temp_p(temp_q),
    .perm_p(perm_q),
    .dual_mode(dual_mode),
    .lc(lc_state),
    .serial_en(serial_en),
    .locked(locked),
    .allow(allow)
  );
  assign req_ready = loaded_q && st_q == st_idle && !fl_busy && !fl_cmd_valid;
  assign take = req_valid && req_ready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      fl_cmd_valid <= 1'b0;
      fl_cmd <= '0;
      err_blk_q <= '0;
    end else begin
      resp_valid <= take;
      resp_err <= take && !allow;
      fl_cmd_valid <= (take && allow) || (st_q == st_issue && !cnt_skip && !fl_busy);
      if (take) fl_cmd <= req;
      else if (st_q == st_issue) begin
        fl_cmd <= '{op: flc_pkg::op_erase, bank: cnt_bank, blk: cnt_blk,
                    target_secure: 1'b0, from_serial: 1'b0};
      end
      if (take && !allow) err_blk_q <= req.blk;
    end
  end
  // secure fault, routed to the secure handler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) secure_fault <= 1'b0;
    else secure_fault <= ax_valid && ax_nonsecure && ax_target_secure;
  end
  //////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over write-one clear
  assign irq_set = {init_refuse, init_done, step_bad, secure_fault, resp_valid && resp_err};
  assign irq_clr = (wr_en && paddr == `FLC_OFF_IRQ_STAT) ? pwdata[`FLC_IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr_en && paddr == `FLC_OFF_IRQ_MASK) irq_mask_q <= pwdata[`FLC_IRQ_W-1:0];
      irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_lock_refuse;
    @(posedge pclk) disable iff (!presetn)
      take && locked && req.op != flc_pkg::op_read |=> resp_valid && resp_err && !fl_cmd_valid;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked block served");
  property p_perm_sticky;
    @(posedge pclk) disable iff (!presetn)
      loaded_q && $past(loaded_q) |-> (perm_q & $past(perm_q)) == $past(perm_q);
  endproperty
  a_perm_sticky: assert property (p_perm_sticky) else $error("permanent lock dropped");
  property p_init_end;
    @(posedge pclk) disable iff (!presetn)
      st_q == st_finish |=> temp_q == '0 && lc_state == flc_pkg::secure_software_dev_state;
  endproperty
  a_init_end: assert property (p_init_end) else $error("initialise end state wrong");
  property p_init_skip;
    @(posedge pclk) disable iff (!presetn)
      fl_cmd_valid && st_q == st_gap |->
        !flc_pkg::prot_bit(perm_q, dual_mode, fl_cmd.bank, fl_cmd.blk);
  endproperty
  a_init_skip: assert property (p_init_skip) else $error("erased a permanent block");
  property p_fault;
    @(posedge pclk) disable iff (!presetn)
      ax_valid && ax_nonsecure && ax_target_secure |=> secure_fault ##1 irq_stat_q[1];
  endproperty
  a_fault: assert property (p_fault) else $error("secure fault missing");
  property p_serial_ns;
    @(posedge pclk) disable iff (!presetn)
      take && req.from_serial && req.target_secure &&
      lc_state == flc_pkg::nonsecure_software_dev_state |=> resp_err;
  endproperty
  a_serial_ns: assert property (p_serial_ns) else $error("serial reached secure");
  property p_serial_dpl;
    @(posedge pclk) disable iff (!presetn)
      take && req.from_serial && (lc_state == flc_pkg::deployed_state ||
      lc_state == flc_pkg::debug_locked_state) |=> resp_err ##0 !fl_cmd_valid;
  endproperty
  a_serial_dpl: assert property (p_serial_dpl) else $error("serial reached flash");
  property p_init_block;
    @(posedge pclk) disable iff (!presetn)
      init_go && lc_state >= flc_pkg::debug_locked_state |=> st_q == st_idle;
  endproperty
  a_init_block: assert property (p_init_block) else $error("initialise in locked state");
  c_refuse: cover property (@(posedge pclk) disable iff (!presetn) resp_valid && resp_err);
  c_init: cover property (@(posedge pclk) disable iff (!presetn) st_q == st_finish);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) secure_fault && irq);
endmodule // flc_top

// file: core/flc_params.svh
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH
// block map
`define FLC_LOW_BLKS 37
`define FLC_HIGH_BLKS 32
`define FLC_DUAL_BLKS 32
`define FLC_NBLK (`FLC_LOW_BLKS + `FLC_HIGH_BLKS)
`define FLC_BLK_W 7
`define FLC_CNT_W 8
`define FLC_LO0_BITS 32
// register byte offsets
`define FLC_OFF_TEMP_LO0 12'h000
`define FLC_OFF_TEMP_LO1 12'h004
`define FLC_OFF_TEMP_HI 12'h008
`define FLC_OFF_TEMP_DB 12'h00C
`define FLC_OFF_PERM_LO0 12'h010
`define FLC_OFF_PERM_LO1 12'h014
`define FLC_OFF_PERM_HI 12'h018
`define FLC_OFF_PERM_DB 12'h01C
`define FLC_OFF_LC 12'h020
`define FLC_OFF_CMD 12'h024
`define FLC_OFF_STATUS 12'h028
`define FLC_OFF_IRQ_STAT 12'h02C
`define FLC_OFF_IRQ_MASK 12'h030
`define FLC_OFF_ERR_BLK 12'h034
// interrupt bits
`define FLC_IRQ_W 5
`define FLC_IRQ_REFUSED 0
`define FLC_IRQ_FAULT 1
`define FLC_IRQ_BAD_STEP 2
`define FLC_IRQ_INIT_DONE 3
`define FLC_IRQ_INIT_REFUSED 4
// command and status bits
`define FLC_CMD_INIT 0
`define FLC_ST_BUSY 0
`define FLC_ST_DEBUG 1
`define FLC_ST_SERIAL 2
`define FLC_ST_DUAL 3
`define FLC_ST_LOADED 4
`endif

// file: core/flc_pkg.sv
`include "flc_params.svh"
package flc_pkg;
  // lifecycle states in path order
  typedef enum logic [2:0] {
    chip_manufacturing_state, secure_software_dev_state, nonsecure_software_dev_state,
    deployed_state, debug_locked_state, boot_locked_state
  } flc_lc_t;
  typedef enum logic [1:0] {op_read, op_program, op_erase} flc_op_t;
  // one protect set: low, high and dual bank words
  typedef struct packed {
    logic [`FLC_DUAL_BLKS-1:0] dual_bank;
    logic [`FLC_HIGH_BLKS-1:0] high_blocks;
    logic [`FLC_LOW_BLKS-1:0] low_blocks;
  } flc_prot_t;
  // flash request from cpu or serial port
  typedef struct packed {
    flc_op_t op;
    logic bank;
    logic [`FLC_BLK_W-1:0] blk;
    logic target_secure;
    logic from_serial;
  } flc_req_t;
  // nonvolatile image
  typedef struct packed {
    flc_lc_t lc;
    flc_prot_t temp_block_protect;
    flc_prot_t perm_block_protect;
  } flc_nv_t;
  // protect bit of one block for the current bank mode
  function automatic logic prot_bit(flc_prot_t p, logic dual, logic bank,
                                    logic [`FLC_BLK_W-1:0] blk);
    logic r;
    r = 1'b0;
    if (dual && bank) begin
      if (blk < `FLC_DUAL_BLKS) r = p.dual_bank[blk[4:0]];
    end else if (blk < `FLC_LOW_BLKS) begin
      r = p.low_blocks[blk[5:0]];
    end else if (blk < `FLC_NBLK) begin
      r = p.high_blocks[5'(blk - `FLC_BLK_W'(`FLC_LOW_BLKS))];
    end
    return r;
  endfunction
  // allowed unauthenticated step
  function automatic logic legal_step(flc_lc_t from, flc_lc_t to);
    return (from == chip_manufacturing_state && to == secure_software_dev_state) ||
           (from == secure_software_dev_state && to == nonsecure_software_dev_state) ||
           (from == nonsecure_software_dev_state && to == deployed_state) ||
           (from == deployed_state && to == debug_locked_state) ||
           (from == debug_locked_state && to == boot_locked_state) ||
           (from == secure_software_dev_state && to == debug_locked_state);
  endfunction
endpackage

// file: core/flc_lifecycle.sv
`timescale 1ns/1ps
`include "flc_params.svh"
module flc_lifecycle (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // state load from nonvolatile store
  input wire logic load_valid,
  input flc_pkg::flc_lc_t load_state,
  // step and initialise requests
  input wire logic step_req,
  input wire logic [2:0] step_target,
  input wire logic init_done,
  // state and port enables
  output flc_pkg::flc_lc_t lc_state,
  output logic step_bad,
  output logic debug_en,
  output logic serial_en
);
  flc_pkg::flc_lc_t lc_q;
  logic loaded_q;
  logic step_ok;
  assign step_ok = flc_pkg::legal_step(lc_q, flc_pkg::flc_lc_t'(step_target));
  //////////////////////////////////////////////////////////////////////////
  // lifecycle state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_q <= flc_pkg::chip_manufacturing_state;
      loaded_q <= 1'b0;
    end else if (load_valid) begin
      lc_q <= load_state;
      loaded_q <= 1'b1;
    end else if (init_done) begin
      lc_q <= flc_pkg::secure_software_dev_state;
    end else if (step_req && step_ok) begin
      lc_q <= flc_pkg::flc_lc_t'(step_target);
    end
  end
  // refused step flag pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) step_bad <= 1'b0;
    else step_bad <= step_req && !step_ok && !init_done;
  end
  // port enables, both off until the stored state is known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_en <= 1'b0;
      serial_en <= 1'b0;
    end else begin
      debug_en <= loaded_q && lc_q < flc_pkg::debug_locked_state;
      serial_en <= loaded_q && lc_q != flc_pkg::boot_locked_state;
    end
  end
  assign lc_state = lc_q;
  //////////////////////////////////////////////////////////////////////////
  property p_debug_dead;
    @(posedge pclk) disable iff (!presetn)
      (lc_q == flc_pkg::debug_locked_state || lc_q == flc_pkg::boot_locked_state)
        |=> !debug_en;
  endproperty
  a_debug_dead: assert property (p_debug_dead) else $error("debug on in locked state");
  property p_serial_dead;
    @(posedge pclk) disable iff (!presetn)
      lc_q == flc_pkg::boot_locked_state |=> !serial_en;
  endproperty
  a_serial_dead: assert property (p_serial_dead) else $error("serial on in boot lock");
  property p_step_path;
    @(posedge pclk) disable iff (!presetn)
      (loaded_q && !$past(load_valid) && !$past(init_done) && lc_q != $past(lc_q))
        |-> flc_pkg::legal_step($past(lc_q), lc_q);
  endproperty
  a_step_path: assert property (p_step_path) else $error("illegal lifecycle step");
endmodule // flc_lifecycle

// file: core/flc_prot_check.sv
`timescale 1ns/1ps
`include "flc_params.svh"
module flc_prot_check (
  // request and settings
  input flc_pkg::flc_req_t req,
  input flc_pkg::flc_prot_t temp_p,
  input flc_pkg::flc_prot_t perm_p,
  input wire logic dual_mode,
  input flc_pkg::flc_lc_t lc,
  input wire logic serial_en,
  // decision
  output logic locked,
  output logic allow
);
  logic port_ok;
  // effective lock is temporary or permanent
  assign locked = flc_pkg::prot_bit(temp_p, dual_mode, req.bank, req.blk) ||
                  flc_pkg::prot_bit(perm_p, dual_mode, req.bank, req.blk);
  // serial port reach per lifecycle state
  always_comb begin
    port_ok = 1'b1;
    if (req.from_serial) begin
      unique case (lc)
        flc_pkg::nonsecure_software_dev_state: port_ok = !req.target_secure;
        flc_pkg::deployed_state, flc_pkg::debug_locked_state: port_ok = 1'b0;
        flc_pkg::boot_locked_state: port_ok = 1'b0;
        default: port_ok = serial_en;
      endcase
      if (!serial_en) port_ok = 1'b0;
    end
  end
  // reads pass the block lock, program and erase do not
  assign allow = port_ok && (req.op == flc_pkg::op_read || !locked);
endmodule // flc_prot_check

// file: bench/flc_flash_model.sv
`timescale 1ns/1ps
module flc_flash_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command and pace
  input wire logic fl_cmd_valid,
  input wire logic slow,
  // engine state
  output logic fl_busy
);
  logic [3:0] cnt_q;
  // busy from the edge after a command, short or long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 4'h0;
    else if (fl_cmd_valid) cnt_q <= slow ? 4'hA : 4'h2;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign fl_busy = (cnt_q != 4'h0);
endmodule // flc_flash_model

// file: bench/flc_top_tb.sv
`timescale 1ns/1ps
`include "flc_params.svh"
module flc_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h00014A8A;
  logic pready, pslverr, nv_valid = 1'b0, nv_wr, dual_mode = 1'b0, req_valid = 1'b0;
  logic req_ready, resp_valid, resp_err, fl_cmd_valid, fl_busy, slow = 1'b0, a_ns, a_ts;
  logic ax_valid = 1'b0, ax_nonsecure = 1'b0, ax_target_secure = 1'b0, secure_fault;
  logic debug_en, serial_en, irq;
  logic [32:0] e;
  logic [12:0] er;
  logic [6:0] blks [6] = '{7'h05, 7'h24, 7'h25, 7'h26, 7'h28, 7'h06};
  logic [5:0] errs = 6'h17;
  flc_pkg::flc_nv_t nv_image = '0, nv_wr_image, last_nv = '0;
  flc_pkg::flc_req_t req = '0, fl_cmd;
  flc_pkg::flc_lc_t lc_state;
  int fail_count = 0, checked = 0, ncmd = 0, base;
  logic [12:0] rq_q[$];
  logic [32:0] rd_q[$];
  always #5 pclk = ~pclk;
  flc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nv_valid(nv_valid), .nv_image(nv_image), .nv_wr(nv_wr),
    .nv_wr_image(nv_wr_image), .dual_mode(dual_mode), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_err(resp_err),
    .fl_cmd_valid(fl_cmd_valid), .fl_cmd(fl_cmd), .fl_busy(fl_busy), .ax_valid(ax_valid),
    .ax_nonsecure(ax_nonsecure), .ax_target_secure(ax_target_secure),
    .secure_fault(secure_fault), .debug_en(debug_en), .serial_en(serial_en),
    .lc_state(lc_state), .irq(irq));
  flc_flash_model i_flash (.pclk(pclk), .presetn(presetn), .fl_cmd_valid(fl_cmd_valid),
    .slow(slow), .fl_busy(fl_busy));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // start just after a rising edge, one idle edge after any earlier transfer
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    rd_q.push_back({err, exp});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rq(input flc_pkg::flc_op_t op, input logic bk, input logic [6:0] b,
                    input logic ts, input logic sr, input logic err);
    flc_pkg::flc_req_t r;
    r = '{op: op, bank: bk, blk: b, target_secure: ts, from_serial: sr};
    @(posedge pclk);
    rnd = lfsr(rnd);
    slow <= rnd[0];
    req <= r;
    req_valid <= 1'b1;
    do begin
      @(posedge pclk);
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    rq_q.push_back({err, r});
    @(posedge pclk);
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // take the oldest note whenever an answer shows
  always @(posedge pclk) begin
    if (fl_cmd_valid === 1'b1) ncmd++;
    if (nv_wr === 1'b1) last_nv = nv_wr_image;
    if (resp_valid === 1'b1) begin
      if (rq_q.size() == 0) check("spare resp", 32'h1, 32'h0);
      else begin
        er = rq_q.pop_front();
        check("resp_err", resp_err, er[12]);
        check("fl_cmd_valid", fl_cmd_valid, !er[12]);
        check("fl_cmd", fl_cmd, er[11:0]);
      end
    end
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      check("pslverr", pslverr, e[32]);
      if (!e[32]) check("prdata", prdata, e[31:0]);
    end
  end
  // watchdog
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    nv_image.lc = flc_pkg::secure_software_dev_state;
    nv_image.temp_block_protect.low_blocks = 37'h10_0000_0020;
    nv_image.temp_block_protect.high_blocks = 32'h1;
    nv_image.perm_block_protect.high_blocks = 32'h8;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    nv_valid <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`FLC_OFF_STATUS, 32'h16, 1'b0);
    rd(12'hFFC, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rq(i[0] ? flc_pkg::op_erase : flc_pkg::op_program, 1'b0, blks[i], rnd[1], 1'b0, errs[i]);
    end
    rq(flc_pkg::op_read, 1'b0, 7'h05, 1'b0, 1'b0, 1'b0);
    apb(1'b1, `FLC_OFF_TEMP_DB, 32'h4);
    dual_mode <= 1'b1;
    rq(flc_pkg::op_program, 1'b1, 7'h02, 1'b0, 1'b0, 1'b1);
    dual_mode <= 1'b0;
    rq(flc_pkg::op_program, 1'b1, 7'h02, 1'b0, 1'b0, 1'b0);
    apb(1'b1, `FLC_OFF_IRQ_STAT, 32'h1F);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a_ns = rnd[2] | (i == 0);
      a_ts = rnd[3] | (i == 0);
      ax_valid <= 1'b1;
      ax_nonsecure <= a_ns;
      ax_target_secure <= a_ts;
      @(posedge pclk);
      ax_valid <= 1'b0;
      @(negedge pclk);
      check("secure_fault", secure_fault, a_ns & a_ts);
      @(posedge pclk);
    end
    rd(`FLC_OFF_IRQ_STAT, 32'h2, 1'b0);
    apb(1'b1, `FLC_OFF_IRQ_MASK, 32'h2);
    settle();
    check("irq", irq, 32'h1);
    apb(1'b1, `FLC_OFF_IRQ_STAT, 32'h2);
    settle();
    check("irq", irq, 32'h0);
    apb(1'b1, `FLC_OFF_LC, 32'h3);
    settle();
    check("lc_state", lc_state, 32'h1);
    apb(1'b1, `FLC_OFF_LC, 32'h2);
    settle();
    check("lc_state", lc_state, 32'h2);
    rq(flc_pkg::op_program, 1'b0, 7'h0A, 1'b1, 1'b1, 1'b1);
    rq(flc_pkg::op_program, 1'b0, 7'h0A, 1'b0, 1'b1, 1'b0);
    apb(1'b1, `FLC_OFF_CMD, 32'h1);
    base = ncmd;
    for (int n = 0; n < 400; n++) begin
      apb(1'b0, `FLC_OFF_STATUS, 32'h0);
      if (prdata[0] === 1'b0) break;
    end
    check("erases", ncmd - base, 32'd68);
    check("lc_state", lc_state, 32'h1);
    rq(flc_pkg::op_program, 1'b0, 7'h05, 1'b0, 1'b0, 1'b0);
    rq(flc_pkg::op_erase, 1'b0, 7'h28, 1'b0, 1'b0, 1'b1);
    rd(`FLC_OFF_ERR_BLK, 32'h28, 1'b0);
    apb(1'b1, `FLC_OFF_PERM_LO0, 32'h400);
    rq(flc_pkg::op_erase, 1'b0, 7'h0A, 1'b0, 1'b0, 1'b1);
    check("nv lc", last_nv.lc, 32'h1);
    check("nv perm", last_nv.perm_block_protect.high_blocks, 32'h8);
    apb(1'b1, `FLC_OFF_LC, 32'h4);
    settle();
    check("debug_en", debug_en, 32'h0);
    rq(flc_pkg::op_program, 1'b0, 7'h05, 1'b0, 1'b1, 1'b1);
    apb(1'b1, `FLC_OFF_LC, 32'h5);
    settle();
    check("serial_en", serial_en, 32'h0);
    rq(flc_pkg::op_read, 1'b0, 7'h05, 1'b0, 1'b1, 1'b1);
    apb(1'b1, `FLC_OFF_CMD, 32'h1);
    settle();
    check("lc_state", lc_state, 32'h5);
    tally_and_finish();
  end
endmodule // flc_top_tb
